/* File: rtl/diag_pkg.sv */
// shared constants and carrier types for the palette diagnostic register
`default_nettype none
package diag_pkg;
   localparam int SEL_W = 3;
   localparam logic [2:0] SEL_RED = 3'h0;
   localparam logic [2:0] SEL_GREEN = 3'h1;
   localparam logic [2:0] SEL_BLUE = 3'h2;
   localparam logic [2:0] SEL_IDENT = 3'h3;
   localparam logic [2:0] SEL_ACC_RED = 3'h4;
   localparam logic [2:0] SEL_ACC_GREEN = 3'h5;
   localparam logic [2:0] SEL_ACC_BLUE = 3'h6;
   localparam logic [2:0] SEL_ANALOG = 3'h7;
   localparam int CMP_SEL_LSB = 4;
   localparam int CMP_RESULT_BIT = 3;
   localparam logic [3:0] CMP_NORMAL = 4'h0;
   localparam logic [3:0] CMP_RED_BLUE = 4'ha;
   localparam logic [3:0] CMP_RED_REF = 4'h9;
   localparam logic [3:0] CMP_GREEN_BLUE = 4'h6;
   localparam logic [3:0] CMP_GREEN_REF = 4'h5;
   localparam logic [2:0] SEL_RESET = 3'h0;
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam int CTRL_SELECT_BIT = 7;
   // arbitrary neutral identification value
   localparam logic [7:0] IDENT_CODE = 8'h5a;

   // one palette word as it enters the converters
   typedef struct packed {
      logic [7:0] red;
      logic [7:0] green;
      logic [7:0] blue;
   } pixel_rgb_t;

   // comparator outputs, one per supported pairing
   typedef struct packed {
      logic red_gt_blue;
      logic red_gt_ref;
      logic green_gt_blue;
      logic green_gt_ref;
   } cmp_in_t;
endpackage
`default_nettype wire

/* File: rtl/ones_counter.sv */
// population count of one colour byte
`timescale 1ns/1ps
`default_nettype none
module ones_counter #(
   parameter int WIDTH = 8
) (
   input wire logic [WIDTH-1:0] data,
   output logic [3:0] count
);
   // simple adder chain, byte is small enough to stay combinational
   always_comb begin
      count = 4'h0;
      for (int i = 0; i < WIDTH; i++) begin
         count = count + {3'h0, data[i]};
      end
   end
endmodule // ones_counter
`default_nettype wire

/* File: rtl/palette_diag_reg.sv */
// diagnostic select/data register with data flow, id, ones accumulation and analog compare
// Contract
// - three-bit channel selector sits in low bits of the register
// - host write loads selector; host read returns selected channel's data
// - selector codes: palette rgb, id, accumulation rgb, analog compare
// - palette channels return converter input byte before 8/6 shift
// - palette read advances selector, blue wraps to red
// - id is fixed; reading it moves selector to red
// - accumulate one bits of full colour byte per accessed word
// - temporary accumulator is eight bits and drops overflow
// - accumulation runs at half pixel rate
// - vsync falling edge latches accumulator then clears it
// - selector moves to another colour after each frame transfer; the code advances it only in the accumulation modes
// - code 111: bits 7..4 compare select rw, bit 3 result ro
// - compare select codes pick comparator pairing; 1 means first larger
// - result captured on falling edge of blank-derived strobe
// - control bit 7 drives external select pin, no other effect
// - external select forced low at reset and in pass-through mode
`timescale 1ns/1ps
`default_nettype none
module palette_diag_reg #(
   parameter logic [7:0] IDENT_VALUE = diag_pkg::IDENT_CODE
) (
   input wire logic CLK_SYS,
   input wire logic RST_N,
   input wire logic PIXEL_CLOCK,
   input wire logic VSYNC_N,
   input wire logic BLANK_N,
   input wire diag_pkg::pixel_rgb_t PIXEL_DATA,
   input wire diag_pkg::cmp_in_t CMP_IN,
   input wire logic HOST_WR,
   input wire logic HOST_RD,
   input wire logic [7:0] HOST_WDATA,
   input wire logic CTRL_WR,
   input wire logic [7:0] CTRL_WDATA,
   input wire logic PASS_THROUGH,
   output logic [7:0] HOST_RDATA,
   output logic EXTERNAL_SELECT_OUT
);
   // pin synchronisers; stage one is read only by stage two
   logic pclk_s1_ff, pclk_s2_ff, pclk_d_ff;
   logic vs_s1_ff, vs_s2_ff, vs_d_ff;
   logic bl_s1_ff, bl_s2_ff, bl_d_ff;
   logic pt_s1_ff, pt_s2_ff;
   diag_pkg::pixel_rgb_t pix_s1_ff, pix_s2_ff;
   diag_pkg::cmp_in_t cmp_s1_ff, cmp_s2_ff;

   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         pclk_s1_ff <= 1'b0;
         pclk_s2_ff <= 1'b0;
         pclk_d_ff <= 1'b0;
         vs_s1_ff <= 1'b1;
         vs_s2_ff <= 1'b1;
         vs_d_ff <= 1'b1;
         bl_s1_ff <= 1'b1;
         bl_s2_ff <= 1'b1;
         bl_d_ff <= 1'b1;
         pt_s1_ff <= 1'b0;
         pt_s2_ff <= 1'b0;
         pix_s1_ff <= '0;
         pix_s2_ff <= '0;
         cmp_s1_ff <= '0;
         cmp_s2_ff <= '0;
      end else begin
         pclk_s1_ff <= PIXEL_CLOCK;
         pclk_s2_ff <= pclk_s1_ff;
         pclk_d_ff <= pclk_s2_ff;
         vs_s1_ff <= VSYNC_N;
         vs_s2_ff <= vs_s1_ff;
         vs_d_ff <= vs_s2_ff;
         bl_s1_ff <= BLANK_N;
         bl_s2_ff <= bl_s1_ff;
         bl_d_ff <= bl_s2_ff;
         pt_s1_ff <= PASS_THROUGH;
         pt_s2_ff <= pt_s1_ff;
         pix_s1_ff <= PIXEL_DATA;
         pix_s2_ff <= pix_s1_ff;
         cmp_s1_ff <= CMP_IN;
         cmp_s2_ff <= cmp_s1_ff;
      end
   end

   // edge detection on synchronised levels; only the vsync pin ends a frame, not composite sync
   wire pclk_rise = pclk_s2_ff & ~pclk_d_ff;
   wire vsync_fall = ~vs_s2_ff & vs_d_ff;
   // blank falling edge is the compare strobe
   wire blank_strobe_fall = ~bl_s2_ff & bl_d_ff;

   // selector, compare select, accumulator state
   logic [2:0] sel_ff, nxt_sel;
   logic [3:0] cmp_sel_ff, nxt_cmp_sel;
   logic cmp_result_ff;
   logic [7:0] temp_acc_ff, nxt_temp_acc;
   logic [7:0] acc_reg_ff;
   logic half_ff;
   logic ctrl_bit_ff;
   logic [7:0] rdata_ff, nxt_rdata;
   logic ext_sel_ff;

   // next colour in the palette ring, blue wraps to red
   function automatic logic [2:0] next_palette(input logic [2:0] s);
      case (s)
         diag_pkg::SEL_RED: next_palette = diag_pkg::SEL_GREEN;
         diag_pkg::SEL_GREEN: next_palette = diag_pkg::SEL_BLUE;
         default: next_palette = diag_pkg::SEL_RED;
      endcase
   endfunction

   // next colour in the accumulation ring
   function automatic logic [2:0] next_accum(input logic [2:0] s);
      case (s)
         diag_pkg::SEL_ACC_RED: next_accum = diag_pkg::SEL_ACC_GREEN;
         diag_pkg::SEL_ACC_GREEN: next_accum = diag_pkg::SEL_ACC_BLUE;
         default: next_accum = diag_pkg::SEL_ACC_RED;
      endcase
   endfunction

   wire is_palette = (sel_ff == diag_pkg::SEL_RED) | (sel_ff == diag_pkg::SEL_GREEN) |
      (sel_ff == diag_pkg::SEL_BLUE);
   wire is_accum = (sel_ff == diag_pkg::SEL_ACC_RED) | (sel_ff == diag_pkg::SEL_ACC_GREEN) |
      (sel_ff == diag_pkg::SEL_ACC_BLUE);
   wire is_analog = (sel_ff == diag_pkg::SEL_ANALOG);

   // colour byte monitored by accumulation
   wire [7:0] acc_byte = (sel_ff == diag_pkg::SEL_ACC_RED) ? pix_s2_ff.red :
      (sel_ff == diag_pkg::SEL_ACC_GREEN) ? pix_s2_ff.green : pix_s2_ff.blue;
   wire [3:0] ones;

   ones_counter #(.WIDTH(8)) u_ones_counter (
      .data(acc_byte),
      .count(ones)
   );

   // every second pixel clock rise counts one palette word
   wire acc_step = pclk_rise & half_ff & is_accum;

   // selected comparator pairing; unknown codes read zero
   wire cmp_now = (cmp_sel_ff == diag_pkg::CMP_RED_BLUE) ? cmp_s2_ff.red_gt_blue :
      (cmp_sel_ff == diag_pkg::CMP_RED_REF) ? cmp_s2_ff.red_gt_ref :
      (cmp_sel_ff == diag_pkg::CMP_GREEN_BLUE) ? cmp_s2_ff.green_gt_blue :
      (cmp_sel_ff == diag_pkg::CMP_GREEN_REF) ? cmp_s2_ff.green_gt_ref : 1'b0;

   // palette byte before the 8/6 shift, steadiness is the host's job
   wire [7:0] pal_byte = (sel_ff == diag_pkg::SEL_RED) ? pix_s2_ff.red :
      (sel_ff == diag_pkg::SEL_GREEN) ? pix_s2_ff.green : pix_s2_ff.blue;

   // read data mux
   wire [7:0] analog_word = {cmp_sel_ff, cmp_result_ff, sel_ff};
   always_comb begin
      nxt_rdata = rdata_ff;
      if (HOST_RD) begin
         if (is_palette) begin
            nxt_rdata = pal_byte;
         end else if (is_accum) begin
            nxt_rdata = acc_reg_ff;
         end else if (is_analog) begin
            nxt_rdata = analog_word;
         end else begin
            nxt_rdata = IDENT_VALUE;
         end
      end
   end

   // selector update: host write, read post-increment, frame advance
   always_comb begin
      nxt_sel = sel_ff;
      nxt_cmp_sel = cmp_sel_ff;
      if (HOST_WR) begin
         nxt_sel = HOST_WDATA[2:0];
         nxt_cmp_sel = HOST_WDATA[7:diag_pkg::CMP_SEL_LSB];
      end else if (HOST_RD && (is_palette || sel_ff == diag_pkg::SEL_IDENT)) begin
         nxt_sel = next_palette(sel_ff);
      end else if (vsync_fall && is_accum) begin
         nxt_sel = next_accum(sel_ff);
      end
   end

   // temporary accumulator wraps modulo 256
   always_comb begin
      nxt_temp_acc = temp_acc_ff;
      if (vsync_fall) begin
         nxt_temp_acc = diag_pkg::ACC_RESET;
      end else if (acc_step) begin
         nxt_temp_acc = temp_acc_ff + {4'h0, ones};
      end
   end

   // frame latch, half-rate toggle, result strobe and control bit as plain next values
   wire [7:0] nxt_acc_reg = vsync_fall ? temp_acc_ff : acc_reg_ff;
   wire nxt_half = pclk_rise ? ~half_ff : half_ff;
   wire nxt_cmp_result = (blank_strobe_fall && is_analog) ? cmp_now : cmp_result_ff;
   wire nxt_ctrl_bit = CTRL_WR ? CTRL_WDATA[diag_pkg::CTRL_SELECT_BIT] : ctrl_bit_ff;

   // selector, compare and readback state
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         sel_ff <= diag_pkg::SEL_RESET;
         cmp_sel_ff <= diag_pkg::CMP_NORMAL;
         rdata_ff <= 8'h00;
      end else begin
         sel_ff <= nxt_sel;
         cmp_sel_ff <= nxt_cmp_sel;
         rdata_ff <= nxt_rdata;
      end
   end

   // accumulation and compare result
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         temp_acc_ff <= diag_pkg::ACC_RESET;
         acc_reg_ff <= diag_pkg::ACC_RESET;
         half_ff <= 1'b0;
         cmp_result_ff <= 1'b0;
      end else begin
         temp_acc_ff <= nxt_temp_acc;
         acc_reg_ff <= nxt_acc_reg;
         half_ff <= nxt_half;
         cmp_result_ff <= nxt_cmp_result;
      end
   end

   // external select pin, pass-through overrides the bit
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         ctrl_bit_ff <= 1'b0;
         ext_sel_ff <= 1'b0;
      end else begin
         ctrl_bit_ff <= nxt_ctrl_bit;
         ext_sel_ff <= ctrl_bit_ff & ~pt_s2_ff;
      end
   end

   assign HOST_RDATA = rdata_ff;
   assign EXTERNAL_SELECT_OUT = ext_sel_ff;

   // id read lands on red unless a write comes in the same cycle
   a_ident_to_red: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      (HOST_RD && !HOST_WR && sel_ff == diag_pkg::SEL_IDENT) |=> (sel_ff == diag_pkg::SEL_RED))
      else $error("id read did not move selector to red");
   // blue read wraps to red
   a_blue_wraps_red: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      (HOST_RD && !HOST_WR && sel_ff == diag_pkg::SEL_BLUE) |=> (sel_ff == diag_pkg::SEL_RED))
      else $error("blue read did not wrap to red");
   // write loads selector
   wire [2:0] wr_sel_field = HOST_WDATA[2:0];
   a_write_loads_sel: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      HOST_WR |=> (sel_ff == $past(wr_sel_field)))
      else $error("selector not loaded by write");
   // id read returns code next cycle
   a_ident_data: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      (HOST_RD && sel_ff == diag_pkg::SEL_IDENT) |=> (HOST_RDATA == IDENT_VALUE))
      else $error("id read wrong value");
   // vsync edge latches and clears
   a_frame_latch: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      vsync_fall |=> (acc_reg_ff == $past(temp_acc_ff)) && (temp_acc_ff == 8'h00))
      else $error("frame transfer wrong");
   // accumulator adds ones count with wrap
   a_acc_adds: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      (acc_step && !vsync_fall) |=> (temp_acc_ff == 8'($past(temp_acc_ff) + $past(ones))))
      else $error("accumulator add wrong");
   // accumulation colour wraps from blue to red at frame end
   a_frame_advance: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      (vsync_fall && !HOST_WR && sel_ff == diag_pkg::SEL_ACC_BLUE) |=> (sel_ff == diag_pkg::SEL_ACC_RED))
      else $error("accumulation colour did not cycle");
   // pass-through forces pin low
   a_pass_low: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      pt_s2_ff |=> !EXTERNAL_SELECT_OUT)
      else $error("select pin high in pass-through");
   // red read steps to green
   a_red_to_green: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      (HOST_RD && !HOST_WR && sel_ff == diag_pkg::SEL_RED) |=> (sel_ff == diag_pkg::SEL_GREEN))
      else $error("red read did not move to green");
   // green read steps to blue
   a_green_to_blue: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      (HOST_RD && !HOST_WR && sel_ff == diag_pkg::SEL_GREEN) |=> (sel_ff == diag_pkg::SEL_BLUE))
      else $error("green read did not move to blue");
   // only a write can bring the selector back to id
   a_sel_never_ident: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      (!HOST_WR && sel_ff != diag_pkg::SEL_IDENT) |=> (sel_ff != diag_pkg::SEL_IDENT))
      else $error("selector returned to id without a write");
   // palette read returns the converter input byte
   a_palette_read: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      (HOST_RD && is_palette) |=> (HOST_RDATA == $past(pal_byte)))
      else $error("palette read wrong value");
   // accumulation read returns the latched register
   a_accum_read: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      (HOST_RD && is_accum) |=> (HOST_RDATA == $past(acc_reg_ff)))
      else $error("accumulation read wrong value");
   // analog read packs compare select, result and selector
   a_analog_read: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      (HOST_RD && is_analog) |=> (HOST_RDATA == {$past(cmp_sel_ff), $past(cmp_result_ff), diag_pkg::SEL_ANALOG}))
      else $error("analog read wrong value");
   // blank fall captures the selected comparator
   a_result_capture: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      (blank_strobe_fall && is_analog) |=> (cmp_result_ff == $past(cmp_now)))
      else $error("compare result not captured");
   // result holds between strobes, host writes cannot touch it
   a_result_hold: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      !(blank_strobe_fall && is_analog) |=> $stable(cmp_result_ff))
      else $error("compare result changed without strobe");
   // pin follows the control bit outside pass-through
   a_ext_follows_bit: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
      !pt_s2_ff |=> (EXTERNAL_SELECT_OUT == $past(ctrl_bit_ff)))
      else $error("select pin does not follow control bit");
endmodule // palette_diag_reg
`default_nettype wire

/* File: dv/video_src.sv */
// raster-side model: pixel clock, vertical sync and blank lines
`timescale 1ns/1ps
`default_nettype none
module video_src (
   input wire logic clk,
   output logic pix_clk,
   output logic vsync_n,
   output logic blank_n
);
   // all lines idle high except the pixel clock, which rests low
   initial begin
      pix_clk = 1'b0;
      vsync_n = 1'b1;
      blank_n = 1'b1;
   end

   // slow clock, eight system cycles a period, so sampled pixel data stays put
   task automatic pix_rises(input int n);
      for (int i = 0; i < 2 * n; i++) begin
         repeat (4) @(negedge clk);
         pix_clk = ~pix_clk;
      end
   endtask

   // one low pulse on sync or blank; converter levels held steady meanwhile
   task automatic pulse(input logic vs);
      if (vs) vsync_n = 1'b0;
      else blank_n = 1'b0;
      repeat (6) @(negedge clk);
      vsync_n = 1'b1;
      blank_n = 1'b1;
      repeat (6) @(negedge clk);
   endtask
endmodule // video_src
`default_nettype wire

/* File: dv/tb.sv */
// self-checking bench for the palette diagnostic register
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic host_wr = 1'b0;
   logic host_rd = 1'b0;
   logic ctrl_wr = 1'b0;
   logic pass_through = 1'b0;
   logic [7:0] host_wdata = 8'h00;
   logic [7:0] ctrl_wdata = 8'h00;
   diag_pkg::pixel_rgb_t pixel_data = {8'hff, 8'h41, 8'h03};
   diag_pkg::cmp_in_t cmp_in = '0;
   logic [7:0] host_rdata;
   logic ext_sel, pix_clk, vsync_n, blank_n;
   int miscompares = 0;
   int total_checks = 0;

   always #5 clk_sys = ~clk_sys;

   palette_diag_reg u_palette_diag_reg (.CLK_SYS(clk_sys), .RST_N(rst_n), .PIXEL_CLOCK(pix_clk),
      .VSYNC_N(vsync_n), .BLANK_N(blank_n), .PIXEL_DATA(pixel_data), .CMP_IN(cmp_in),
      .HOST_WR(host_wr), .HOST_RD(host_rd), .HOST_WDATA(host_wdata), .CTRL_WR(ctrl_wr),
      .CTRL_WDATA(ctrl_wdata), .PASS_THROUGH(pass_through), .HOST_RDATA(host_rdata),
      .EXTERNAL_SELECT_OUT(ext_sel));

   video_src u_video_src (.clk(clk_sys), .pix_clk(pix_clk), .vsync_n(vsync_n), .blank_n(blank_n));

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // one-cycle pulses, launched and dropped on falling edges
   task automatic wr(input logic [7:0] d);
      host_wdata = d;
      host_wr = 1'b1;
      @(negedge clk_sys);
      host_wr = 1'b0;
      @(negedge clk_sys);
   endtask

   task automatic rd(input string what, input logic [7:0] exp);
      host_rd = 1'b1;
      @(negedge clk_sys);
      host_rd = 1'b0;
      @(negedge clk_sys);
      check(what, host_rdata, exp);
   endtask

   // pin goes through a synchroniser, so allow a few cycles
   task automatic wait_sel(input logic exp);
      int n;
      n = 0;
      while (ext_sel !== exp && n < 10) begin
         @(negedge clk_sys);
         n++;
      end
      check("external select", {7'h00, ext_sel}, {7'h00, exp});
      if (n == 10) report_and_stop();
   endtask

   task automatic t_reset();
      check("read data", host_rdata, 8'h00);
      check("external select", {7'h00, ext_sel}, 8'h00);
   endtask

   // green, blue, then wrap to red
   task automatic t_palette();
      wr(8'h01);
      rd("palette green", 8'h41);
      rd("palette blue", 8'h03);
      rd("palette red", 8'hff);
   endtask

   task automatic t_ident();
      logic [7:0] col[3] = '{8'hff, 8'h41, 8'h03};
      wr({5'h00, diag_pkg::SEL_IDENT});
      rd("ident", diag_pkg::IDENT_CODE);
      for (int i = 0; i < 5; i++) rd("after ident", col[i % 3]);
   endtask

   // red overflows (35 counted x 8 = 280), then green, blue, wrap to red
   task automatic t_accum();
      int rises[4] = '{70, 10, 4, 2};
      logic [7:0] exp[4] = '{8'h18, 8'h0a, 8'h04, 8'h08};
      wr({5'h00, diag_pkg::SEL_ACC_RED});
      for (int f = 0; f < 4; f++) begin
         u_video_src.pix_rises(rises[f]);
         u_video_src.pulse(1'b1);
         rd("ones accumulation", exp[f]);
      end
   endtask

   // each pairing sees its own comparator only; later changes ignored until blank falls
   task automatic t_analog();
      logic [3:0] code[4] = '{4'ha, 4'h9, 4'h6, 4'h5};
      for (int i = 0; i < 4; i++) begin
         for (int r = 0; r < 2; r++) begin
            cmp_in = r[0] ? 4'(1 << (3 - i)) : ~4'(1 << (3 - i));
            wr({code[i], 4'h7});
            repeat (3) @(negedge clk_sys);
            u_video_src.pulse(1'b0);
            cmp_in = ~cmp_in;
            repeat (3) @(negedge clk_sys);
            rd("analog compare", {code[i], r[0], 3'h7});
         end
      end
      cmp_in = '1;
      wr(8'h07);
      rd("analog result held", 8'h0f);
      u_video_src.pulse(1'b0);
      rd("analog normal", 8'h07);
   endtask

   task automatic t_ext();
      ctrl_wdata = 8'h80;
      ctrl_wr = 1'b1;
      @(negedge clk_sys);
      ctrl_wr = 1'b0;
      wait_sel(1'b1);
      pass_through = 1'b1;
      wait_sel(1'b0);
      pass_through = 1'b0;
      wait_sel(1'b1);
      ctrl_wdata = 8'h7f;
      ctrl_wr = 1'b1;
      @(negedge clk_sys);
      ctrl_wr = 1'b0;
      wait_sel(1'b0);
   endtask

   initial begin
      repeat (12) @(negedge clk_sys);
      rst_n = 1'b1;
      t_reset();
      t_palette();
      t_ident();
      t_accum();
      t_analog();
      t_ext();
      report_and_stop();
   end
endmodule // tb
`default_nettype wire
